// >>> gate_driver_config_regs_test.sv
// testbench: register bank model compared with the design
module gate_driver_config_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import gdc_pkg::*;
    logic REF_CLK, ARST_N, SCLK, SDI, CS_N, SDO, PWM_EDGE, OC_FAULT, COAST, BRAKE;
    logic REGS_LOCKED, DS_MONITOR_ON, REF_HALF, LS_MEAS_SENSE_NEG, CAL_ENABLE;
    logic AUTO_CAL_ENABLE, SDO_OE;
    logic [2:0] DS_OC_IN, SENSE_OC_IN, BRIDGE_OFF, DS_OC_FLAGS, SENSE_OC_FLAGS;
    ma_t        HS_SOURCE_MA, HS_SINK_MA, LS_SOURCE_MA, LS_SINK_MA;
    logic [8:0] PEAK_DRIVE_CYCLES;
    logic [5:0] DEAD_TIME_CYCLES, AMP_GAIN;
    mv_t        DS_TRIP_MV, SENSE_TRIP_MV;
    int         failures = 0;
    int         n_tests = 0;
    word_t      m[2:15];
    word_t      d;
    logic       lk;
    logic [15:0] sd = 16'h0de7;

    gdc_config_regs #(.RETRY_LONG_CYC(40), .RETRY_SHORT_CYC(10)) i_gdc_config_regs (
        .REF_CLK, .ARST_N, .SCLK, .SDI, .CS_N, .SDO, .SDO_OE, .PWM_EDGE, .DS_OC_IN,
        .SENSE_OC_IN, .BRIDGE_OFF, .OC_FAULT, .DS_OC_FLAGS, .SENSE_OC_FLAGS, .COAST,
        .BRAKE, .REGS_LOCKED, .HS_SOURCE_MA, .HS_SINK_MA, .LS_SOURCE_MA, .LS_SINK_MA,
        .PEAK_DRIVE_CYCLES, .DEAD_TIME_CYCLES, .DS_TRIP_MV, .DS_MONITOR_ON,
        .SENSE_TRIP_MV, .AMP_GAIN, .REF_HALF, .LS_MEAS_SENSE_NEG, .CAL_ENABLE,
        .AUTO_CAL_ENABLE);
    gdc_host_model i_gdc_host_model (.clk(REF_CLK), .sdo(SDO), .sclk(SCLK), .sdi(SDI),
        .cs_n(CS_N));

    initial
    begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    // data line drive enable follows frame select
    always @(negedge REF_CLK)
        if (ARST_N === 1'b1)
            chk("sdo_oe", !CS_N, SDO_OE);

    function automatic logic [15:0] lf(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic wrap_up();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
        end
    endtask

    // write frame plus model update; lock state follows the lock field
    task automatic wr(input logic [3:0] a, input word_t v);
        word_t r;
        i_gdc_host_model.xfer({1'b0, a, v}, r);
        if (a == ADDR_DRV_CTRL)
            m[2] = {8'h00, v[2:1], 1'b0};
        if (!lk && a > 4'h2 && a < 4'h7)
            m[a] = v;
        if (a == ADDR_HS_GATE && v[10:8] == (lk ? UNLOCK_CODE : LOCK_CODE))
            lk = ~lk;
    endtask

    // the lock field reads back the current lock state
    task automatic rdchk(input logic [3:0] a);
        word_t r;
        word_t e;
        e = (a == ADDR_HS_GATE) ? {(lk ? LOCK_CODE : UNLOCK_CODE), m[3][7:0]} : m[a];
        i_gdc_host_model.xfer({1'b1, a, 11'h000}, r);
        chk("read", e, r);
    endtask

    task automatic dec();
        int s[8] = '{15, 15, 45, 60, 90, 105, 135, 150};
        int v[8] = '{150, 240, 400, 510, 600, 900, 1800, 0};
        chk("hs_src", s[m[3][6:4]], HS_SOURCE_MA);
        chk("hs_snk", 2 * s[m[3][2:0]], HS_SINK_MA);
        chk("ls_src", s[m[4][6:4]], LS_SOURCE_MA);
        chk("ls_snk", 2 * s[m[4][2:0]], LS_SINK_MA);
        chk("peak", 50 << m[4][9:8], PEAK_DRIVE_CYCLES);
        chk("dead", 5 << m[5][9:8], DEAD_TIME_CYCLES);
        chk("ds_trip", v[m[5][2:0]], DS_TRIP_MV);
        chk("ds_on", m[5][2:0] != TRIP_OFF, DS_MONITOR_ON);
        chk("se_trip", 250 * (int'(m[6][1:0]) + 1), SENSE_TRIP_MV);
        chk("gain", 5 << m[6][7:6], AMP_GAIN);
        chk("ref", m[6][9], REF_HALF);
        chk("meas", m[6][8], LS_MEAS_SENSE_NEG);
        chk("cal", m[6][4], CAL_ENABLE);
        chk("acal", m[6][3], AUTO_CAL_ENABLE);
    endtask

    task automatic flt(input word_t oc, input logic [2:0] ds, input logic [2:0] se);
        logic [2:0] ed, es, eo;
        int n, rt;
        wr(ADDR_OC_CTRL, oc);
        // retry lengths as set on the instance
        rt = oc[10] ? 10 : 40;
        ed = (oc[7:6] == OC_IGNORE || oc[2:0] == TRIP_OFF) ? 3'b000 : ds;
        es = (oc[7:6] == OC_IGNORE || m[6][5]) ? 3'b000 : se;
        eo = (oc[7] || (ed | es) == 3'b000) ? 3'b000 : (oc[5] ? ed | es : 3'b111);
        @(posedge REF_CLK);
        DS_OC_IN    <= ds;
        SENSE_OC_IN <= se;
        @(posedge REF_CLK);
        DS_OC_IN    <= 3'b000;
        SENSE_OC_IN <= 3'b000;
        repeat (3) @(posedge REF_CLK);
        @(negedge REF_CLK);
        chk("ds_flags", ed, DS_OC_FLAGS);
        chk("se_flags", es, SENSE_OC_FLAGS);
        chk("fault", |(ed | es), OC_FAULT);
        chk("off", eo, BRIDGE_OFF);
        if (oc[7:6] == OC_RETRY && (oc[10] || !m[4][10]))
        begin
            n = 0;
            while (OC_FAULT !== 1'b0 && n < 60)
            begin
                @(negedge REF_CLK);
                n++;
            end
            chk("retry", 1, n > rt - 6 && n < rt + 3);
        end
        else if (oc[7:6] == OC_RETRY)
        begin
            @(posedge REF_CLK) PWM_EDGE <= 1'b1;
            @(posedge REF_CLK) PWM_EDGE <= 1'b0;
            repeat (2) @(posedge REF_CLK);
            @(negedge REF_CLK);
            chk("cbc", 0, OC_FAULT);
        end
        else
        begin
            repeat (50) @(posedge REF_CLK);
            @(negedge REF_CLK);
            chk("latch", |(ed | es), OC_FAULT);
            wr(ADDR_DRV_CTRL, 11'h001);
            chk("clear", 0, OC_FAULT);
        end
        @(negedge REF_CLK);
        chk("off_end", 0, BRIDGE_OFF);
    endtask

    initial
    begin
        static word_t tab[6] = '{11'h545, 11'h045, 11'h025, 11'h085, 11'h0c5, 11'h007};
        static logic [2:0] dsv[6] = '{3'h1, 3'h0, 3'h2, 3'h4, 3'h7, 3'h7};
        static logic [2:0] sev[6] = '{3'h0, 3'h4, 3'h0, 3'h1, 3'h0, 3'h0};
        ARST_N = 1'b0;
        PWM_EDGE = 1'b0;
        DS_OC_IN = 3'b000;
        SENSE_OC_IN = 3'b000;
        lk = 1'b0;
        foreach (m[i]) m[i] = '0;
        m[3] = HS_GATE_RST;
        m[4] = LS_GATE_RST;
        m[5] = OC_CTRL_RST;
        m[6] = AMP_CTRL_RST;
        repeat (20) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        @(negedge REF_CLK);
        dec();
        chk("locked", 0, REGS_LOCKED);
        for (int a = 2; a < 10; a++) rdchk(a[3:0]);
        repeat (6)
        begin
            for (int a = 3; a < 7; a++)
            begin
                sd = lf(sd);
                d = sd[10:0];
                if (a == 3 && d[10:8] == LOCK_CODE)
                    d[10:8] = 3'b000;
                wr(a[3:0], d);
                rdchk(a[3:0]);
            end
            dec();
            chk("locked", 0, REGS_LOCKED);
        end
        wr(ADDR_HS_GATE, {LOCK_CODE, m[3][7:0]});
        chk("locked", 1, REGS_LOCKED);
        wr(ADDR_LS_GATE, ~m[4]);
        rdchk(ADDR_LS_GATE);
        wr(ADDR_HS_GATE, {3'b101, ~m[3][7:0]});
        rdchk(ADDR_HS_GATE);
        chk("locked", 1, REGS_LOCKED);
        wr(ADDR_DRV_CTRL, 11'h006);
        rdchk(ADDR_DRV_CTRL);
        chk("coast", m[2][2], COAST);
        chk("brake", m[2][1], BRAKE);
        dec();
        wr(ADDR_HS_GATE, {UNLOCK_CODE, m[3][7:0]});
        chk("locked", 0, REGS_LOCKED);
        wr(ADDR_LS_GATE, 11'h777);
        wr(ADDR_AMP_CTRL, AMP_CTRL_RST);
        foreach (tab[i]) flt(tab[i], dsv[i], sev[i]);
        wr(ADDR_LS_GATE, 11'h377);
        flt(11'h145, 3'b001, 3'b000);
        wr(ADDR_AMP_CTRL, 11'h2a3);
        flt(11'h005, 3'b001, 3'b111);
        wrap_up();
    end
endmodule

// >>> gdc_config_regs.sv
// gate driver configuration registers, lock and overcurrent response

module gdc_config_regs #(
    parameter int RETRY_LONG_CYC  = gdc_pkg::RETRY_LONG_CYC_DEF,
    parameter int RETRY_SHORT_CYC = gdc_pkg::RETRY_SHORT_CYC_DEF
)(
    input  logic         REF_CLK,
    input  logic         ARST_N,
    input  logic         SCLK,
    input  logic         SDI,
    input  logic         CS_N,
    output logic         SDO,
    output logic         SDO_OE,
    input  logic         PWM_EDGE,
    input  logic [2:0]   DS_OC_IN,
    input  logic [2:0]   SENSE_OC_IN,
    output logic [2:0]   BRIDGE_OFF,
    output logic         OC_FAULT,
    output logic [2:0]   DS_OC_FLAGS,
    output logic [2:0]   SENSE_OC_FLAGS,
    output logic         COAST,
    output logic         BRAKE,
    output logic         REGS_LOCKED,
    output gdc_pkg::ma_t HS_SOURCE_MA,
    output gdc_pkg::ma_t HS_SINK_MA,
    output gdc_pkg::ma_t LS_SOURCE_MA,
    output gdc_pkg::ma_t LS_SINK_MA,
    output logic [8:0]   PEAK_DRIVE_CYCLES,
    output logic [5:0]   DEAD_TIME_CYCLES,
    output gdc_pkg::mv_t DS_TRIP_MV,
    output logic         DS_MONITOR_ON,
    output gdc_pkg::mv_t SENSE_TRIP_MV,
    output logic [5:0]   AMP_GAIN,
    output logic         REF_HALF,
    output logic         LS_MEAS_SENSE_NEG,
    output logic         CAL_ENABLE,
    output logic         AUTO_CAL_ENABLE
);
    import gdc_pkg::*;

    logic         locked_r;
    logic [7:0]   hs_lo_r;
    word_t        ls_r;
    word_t        oc_r;
    word_t        amp_r;
    logic         coast_r;
    logic         brake_r;
    logic         clr_pulse_r;
    logic [2:0]   ds_flag_r;
    logic [2:0]   sen_flag_r;
    logic [19:0]  retry_cnt_r;
    logic [2:0]   bridge_off_r;
    logic         wr_en;
    addr_t        wr_addr;
    word_t        wr_data;
    addr_t        rd_addr;
    word_t        rd_data;
    logic         cfg_wr;
    gdc_oc_mode_t mode;
    logic [2:0]   ds_ev;
    logic [2:0]   sen_ev;
    logic [2:0]   ds_flag_nxt;
    logic [2:0]   sen_flag_nxt;
    logic         any_flag;
    logic         any_set;
    logic         retry_done;
    logic         cbc_clear;
    logic         flag_clear;
    logic [19:0]  retry_limit;

    // source current in mA; sink is twice the source figure
    function automatic ma_t src_ma(input logic [2:0] code);
        case (code)
            3'd0:    src_ma = 9'd15;
            3'd1:    src_ma = 9'd15;
            3'd2:    src_ma = 9'd45;
            3'd3:    src_ma = 9'd60;
            3'd4:    src_ma = 9'd90;
            3'd5:    src_ma = 9'd105;
            3'd6:    src_ma = 9'd135;
            default: src_ma = 9'd150;
        endcase
    endfunction
    function automatic mv_t trip_mv(input logic [2:0] code);
        case (code)
            3'd0:    trip_mv = 11'd150;
            3'd1:    trip_mv = 11'd240;
            3'd2:    trip_mv = 11'd400;
            3'd3:    trip_mv = 11'd510;
            3'd4:    trip_mv = 11'd600;
            3'd5:    trip_mv = 11'd900;
            3'd6:    trip_mv = 11'd1800;
            default: trip_mv = 11'd0;
        endcase
    endfunction
    function automatic logic is_cfg(input addr_t a);
        is_cfg = (a == ADDR_LS_GATE) || (a == ADDR_OC_CTRL) || (a == ADDR_AMP_CTRL);
    endfunction
    gdc_serial_port u_port (
        .clk     (REF_CLK),
        .arst_n  (ARST_N),
        .sclk    (SCLK),
        .sdi     (SDI),
        .cs_n    (CS_N),
        .sdo     (SDO),
        .sdo_oe  (SDO_OE),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data)
    );

    assign cfg_wr = wr_en && !locked_r;

    // lock state: only the exact codes change it
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            locked_r <= 1'b0;
        else if (wr_en && wr_addr == ADDR_HS_GATE)
        begin
            if (!locked_r && wr_data[LOCK_LSB +: 3] == LOCK_CODE)
                locked_r <= 1'b1;
            else if (locked_r && wr_data[LOCK_LSB +: 3] == UNLOCK_CODE)
                locked_r <= 1'b0;
        end
    end

    // configuration registers, frozen while locked
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            hs_lo_r <= HS_GATE_RST[7:0];
            ls_r    <= LS_GATE_RST;
            oc_r    <= OC_CTRL_RST;
            amp_r   <= AMP_CTRL_RST;
        end
        else if (cfg_wr)
        begin
            case (wr_addr)
                ADDR_HS_GATE:  hs_lo_r <= wr_data[7:0];
                ADDR_LS_GATE:  ls_r    <= wr_data;
                ADDR_OC_CTRL:  oc_r    <= wr_data;
                ADDR_AMP_CTRL: amp_r   <= wr_data;
                default:       hs_lo_r <= hs_lo_r;
            endcase
        end
    end

    // driver control bits stay writable under lock; clear bit self resets
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            coast_r     <= 1'b0;
            brake_r     <= 1'b0;
            clr_pulse_r <= 1'b0;
        end
        else
        begin
            clr_pulse_r <= wr_en && wr_addr == ADDR_DRV_CTRL && wr_data[CLR_POS];
            if (wr_en && wr_addr == ADDR_DRV_CTRL)
            begin
                coast_r <= wr_data[COAST_POS];
                brake_r <= wr_data[BRAKE_POS];
            end
        end
    end

    always_comb
    begin
        case (rd_addr)
            ADDR_DRV_CTRL: rd_data = {8'h00, coast_r, brake_r, 1'b0};
            ADDR_HS_GATE:  rd_data = {(locked_r ? LOCK_CODE : UNLOCK_CODE), hs_lo_r};
            ADDR_LS_GATE:  rd_data = ls_r;
            ADDR_OC_CTRL:  rd_data = oc_r;
            ADDR_AMP_CTRL: rd_data = amp_r;
            default:       rd_data = 11'h000;
        endcase
    end

    // overcurrent event qualification
    assign mode    = gdc_oc_mode_t'(oc_r[MODE_LSB +: 2]);
    assign ds_ev   = (oc_r[TRIP_LSB +: 3] != TRIP_OFF && mode != OC_IGNORE)
                     ? DS_OC_IN : 3'b000;
    assign sen_ev  = (!amp_r[SDIS_POS] && mode != OC_IGNORE)
                     ? SENSE_OC_IN : 3'b000;
    assign any_flag = |{ds_flag_r, sen_flag_r};
    assign any_set  = |{ds_ev, sen_ev};
    assign retry_limit = oc_r[RETRY_POS] ? 20'(RETRY_SHORT_CYC - 1)
                                         : 20'(RETRY_LONG_CYC - 1);
    assign retry_done = mode == OC_RETRY && any_flag && retry_cnt_r >= retry_limit;
    assign cbc_clear  = mode == OC_RETRY && ls_r[CBC_POS] && PWM_EDGE;
    assign flag_clear = clr_pulse_r || retry_done || cbc_clear;
    assign ds_flag_nxt  = ds_ev  | (ds_flag_r  & ~{3{flag_clear}});
    assign sen_flag_nxt = sen_ev | (sen_flag_r & ~{3{flag_clear}});

    // new events win over a clear in the same cycle
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ds_flag_r  <= 3'b000;
            sen_flag_r <= 3'b000;
        end
        else
        begin
            ds_flag_r  <= ds_flag_nxt;
            sen_flag_r <= sen_flag_nxt;
        end
    end

    // retry interval restarts on every new event
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            retry_cnt_r <= 20'h0_0000;
        else if (any_set || !any_flag || mode != OC_RETRY)
            retry_cnt_r <= 20'h0_0000;
        else
            retry_cnt_r <= retry_cnt_r + 20'h0_0001;
    end

    // shutdown only in latched or retry mode
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            bridge_off_r <= 3'b000;
        else if (mode == OC_LATCH || mode == OC_RETRY)
            bridge_off_r <= oc_r[SCOPE_POS] ? (ds_flag_r | sen_flag_r)
                                            : {3{any_flag}};
        else
            bridge_off_r <= 3'b000;
    end

    // decoded settings, held in flip-flops
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            HS_SOURCE_MA      <= 9'h000;
            HS_SINK_MA        <= 9'h000;
            LS_SOURCE_MA      <= 9'h000;
            LS_SINK_MA        <= 9'h000;
            PEAK_DRIVE_CYCLES <= 9'h000;
            DEAD_TIME_CYCLES  <= 6'h00;
            DS_TRIP_MV        <= 11'h000;
            DS_MONITOR_ON     <= 1'b0;
            SENSE_TRIP_MV     <= 11'h000;
            AMP_GAIN          <= 6'h00;
            REF_HALF          <= 1'b0;
            LS_MEAS_SENSE_NEG <= 1'b0;
            CAL_ENABLE        <= 1'b0;
            AUTO_CAL_ENABLE   <= 1'b0;
        end
        else
        begin
            HS_SOURCE_MA      <= src_ma(hs_lo_r[SRC_LSB +: 3]);
            HS_SINK_MA        <= 9'(src_ma(hs_lo_r[SINK_LSB +: 3]) << 1);
            LS_SOURCE_MA      <= src_ma(ls_r[SRC_LSB +: 3]);
            LS_SINK_MA        <= 9'(src_ma(ls_r[SINK_LSB +: 3]) << 1);
            PEAK_DRIVE_CYCLES <= 9'(PEAK_BASE_CYC << ls_r[PEAK_LSB +: 2]);
            DEAD_TIME_CYCLES  <= 6'(DEAD_BASE_CYC << oc_r[DEAD_LSB +: 2]);
            DS_TRIP_MV        <= trip_mv(oc_r[TRIP_LSB +: 3]);
            DS_MONITOR_ON     <= oc_r[TRIP_LSB +: 3] != TRIP_OFF;
            SENSE_TRIP_MV     <= 11'(250 * (amp_r[SLVL_LSB +: 2] + 3'd1));
            AMP_GAIN          <= 6'(5 << amp_r[GAIN_LSB +: 2]);
            REF_HALF          <= amp_r[REF_POS];
            LS_MEAS_SENSE_NEG <= amp_r[MEAS_POS];
            CAL_ENABLE        <= amp_r[CAL_POS];
            AUTO_CAL_ENABLE   <= amp_r[ACAL_POS];
        end
    end

    assign BRIDGE_OFF     = bridge_off_r;
    assign OC_FAULT       = any_flag;
    assign DS_OC_FLAGS    = ds_flag_r;
    assign SENSE_OC_FLAGS = sen_flag_r;
    assign COAST          = coast_r;
    assign BRAKE          = brake_r;
    assign REGS_LOCKED    = locked_r;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_locked_cfg_write;
        locked_r && wr_en && is_cfg(wr_addr);
    endsequence
    sequence s_unlock_write;
        locked_r && wr_en && wr_addr == ADDR_HS_GATE && wr_data[LOCK_LSB +: 3] == UNLOCK_CODE;
    endsequence
    property p_lock_hold;
        s_locked_cfg_write |=> $stable(ls_r) && $stable(oc_r) && $stable(amp_r);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("write passed lock");
    property p_bad_lock_code;
        !locked_r && wr_en && wr_addr == ADDR_HS_GATE && wr_data[LOCK_LSB +: 3] != LOCK_CODE
            |=> !locked_r;
    endproperty
    a_bad_lock_code: assert property (p_bad_lock_code) else $error("bad code locked");
    property p_unlock;
        s_unlock_write |=> !locked_r ##1 rd_addr != ADDR_HS_GATE
            || rd_data[LOCK_LSB +: 3] == UNLOCK_CODE;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock failed");
    property p_clear_pulse;
        wr_en && wr_addr == ADDR_DRV_CTRL && wr_data[CLR_POS] |=> clr_pulse_r ##1 !clr_pulse_r;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear not one pulse");
    property p_latched_stays;
        mode == OC_LATCH && any_flag && !clr_pulse_r |=> any_flag;
    endproperty
    a_latched_stays: assert property (p_latched_stays) else $error("latched fault lost");
    property p_ignore_mode;
        mode == OC_IGNORE && !any_flag |=> !any_flag;
    endproperty
    a_ignore_mode: assert property (p_ignore_mode) else $error("ignored fault reported");
    property p_report_only;
        BRIDGE_OFF != 3'b000 |-> $past(mode) == OC_LATCH || $past(mode) == OC_RETRY;
    endproperty
    a_report_only: assert property (p_report_only) else $error("report mode shut bridge");
    property p_scope_all;
        !oc_r[SCOPE_POS] && mode == OC_LATCH && any_flag |=> BRIDGE_OFF == 3'b111;
    endproperty
    a_scope_all: assert property (p_scope_all) else $error("not all bridges off");
    property p_ds_disabled;
        oc_r[TRIP_LSB +: 3] == TRIP_OFF && ds_flag_r == 3'b000 |=> ds_flag_r == 3'b000;
    endproperty
    a_ds_disabled: assert property (p_ds_disabled) else $error("disabled monitor tripped");
    property p_sense_disabled;
        amp_r[SDIS_POS] && sen_flag_r == 3'b000 |=> sen_flag_r == 3'b000;
    endproperty
    a_sense_disabled: assert property (p_sense_disabled) else $error("sense not masked");
    property p_cbc_clear;
        mode == OC_RETRY && ls_r[CBC_POS] && PWM_EDGE && !any_set && any_flag |=> !any_flag;
    endproperty
    a_cbc_clear: assert property (p_cbc_clear) else $error("pwm did not clear fault");
    property p_src_max;
        hs_lo_r[SRC_LSB +: 3] == 3'b111 |=> HS_SOURCE_MA == 9'd150;
    endproperty
    a_src_max: assert property (p_src_max) else $error("source code decode wrong");
endmodule

// >>> gdc_host_model.sv
// host model: serial master framing 16-bit register accesses
module gdc_host_model
    import gdc_pkg::*;
(
    input  wire logic clk,
    input  wire logic sdo,
    output logic      sclk,
    output logic      sdi,
    output logic      cs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sclk = 1'b0;
        sdi  = 1'b0;
        cs_n = 1'b1;
    end
    // msb first; data bits are read just before each falling serial clock
    task automatic xfer(input logic [15:0] f, output word_t rd);
        rd = '0;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge clk);
            sclk <= 1'b1;
            sdi  <= f[i];
            repeat (4) @(posedge clk);
            @(negedge clk);
            if (i <= 10)
                rd[i] = sdo;
            @(posedge clk) sclk <= 1'b0;
            repeat (2) @(posedge clk);
        end
        @(posedge clk);
        cs_n <= 1'b1;
        // released data line must not keep showing the last bit
        sdi  <= ~sdi;
        repeat (5) @(posedge clk);
    endtask
endmodule

// >>> gdc_pkg.sv
// shared constants and types for the gate driver configuration bank
package gdc_pkg;
    typedef logic [8:0]  ma_t;
    typedef logic [10:0] mv_t;
    typedef logic [10:0] word_t;
    typedef logic [3:0]  addr_t;

    // serial frame layout: rw, 4 address bits, 11 data bits
    localparam int    FRAME_BITS   = 16;
    localparam int    HDR_BITS     = 5;
    localparam int    RW_POS       = 15;
    localparam int    ADDR_MSB     = 14;
    localparam int    ADDR_LSB     = 11;

    localparam addr_t ADDR_DRV_CTRL = 4'h2;
    localparam addr_t ADDR_HS_GATE  = 4'h3;
    localparam addr_t ADDR_LS_GATE  = 4'h4;
    localparam addr_t ADDR_OC_CTRL  = 4'h5;
    localparam addr_t ADDR_AMP_CTRL = 4'h6;

    localparam word_t HS_GATE_RST  = 11'h377;
    localparam word_t LS_GATE_RST  = 11'h777;
    localparam word_t OC_CTRL_RST  = 11'h145;
    localparam word_t AMP_CTRL_RST = 11'h283;

    localparam logic [2:0] LOCK_CODE   = 3'b110;
    localparam logic [2:0] UNLOCK_CODE = 3'b011;
    localparam int    LOCK_LSB     = 8;
    localparam int    SRC_LSB      = 4;
    localparam int    SINK_LSB     = 0;
    localparam int    CBC_POS      = 10;
    localparam int    PEAK_LSB     = 8;
    localparam int    RETRY_POS    = 10;
    localparam int    DEAD_LSB     = 8;
    localparam int    MODE_LSB     = 6;
    localparam int    SCOPE_POS    = 5;
    localparam int    TRIP_LSB     = 0;
    localparam logic [2:0] TRIP_OFF = 3'b111;
    localparam int    REF_POS      = 9;
    localparam int    MEAS_POS     = 8;
    localparam int    GAIN_LSB     = 6;
    localparam int    SDIS_POS     = 5;
    localparam int    CAL_POS      = 4;
    localparam int    ACAL_POS     = 3;
    localparam int    SLVL_LSB     = 0;
    localparam int    CLR_POS      = 0;
    localparam int    BRAKE_POS    = 1;
    localparam int    COAST_POS    = 2;

    typedef enum logic [1:0] {
        OC_LATCH  = 2'b00,
        OC_RETRY  = 2'b01,
        OC_REPORT = 2'b10,
        OC_IGNORE = 2'b11
    } gdc_oc_mode_t;

    localparam int    CLK_PERIOD_NS  = 10;
    localparam int    DEAD_BASE_NS   = 50;
    localparam int    PEAK_BASE_NS   = 500;
    localparam int    DEAD_BASE_CYC  = (DEAD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int    PEAK_BASE_CYC  = (PEAK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int    RETRY_LONG_US  = 4000;
    localparam int    RETRY_SHORT_US = 50;
    localparam int    RETRY_LONG_CYC_DEF  = RETRY_LONG_US * 1000 / CLK_PERIOD_NS;
    localparam int    RETRY_SHORT_CYC_DEF = RETRY_SHORT_US * 1000 / CLK_PERIOD_NS;
endpackage

// >>> gdc_serial_port.sv
// serial register port: 16-bit frames, sampled on falling clock edge
module gdc_serial_port
    import gdc_pkg::*;
(
    input  logic  clk,
    input  logic  arst_n,
    input  logic  sclk,
    input  logic  sdi,
    input  logic  cs_n,
    output logic  sdo,
    output logic  sdo_oe,
    output addr_t rd_addr,
    input  word_t rd_data,
    output logic  wr_en,
    output addr_t wr_addr,
    output word_t wr_data
);
    logic        sclk_d_r;
    logic        cs_d_r;
    logic [4:0]  cnt_r;
    logic [15:0] shift_r;
    logic [10:0] tx_r;
    addr_t       addr_r;
    logic        fall;
    logic        rise;

    assign fall   = sclk_d_r & ~sclk & ~cs_n;
    assign rise   = ~sclk_d_r & sclk & ~cs_n;
    assign sdo    = tx_r[10];
    assign sdo_oe = ~cs_n;
    assign rd_addr = addr_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b1;
        end
        else
        begin
            sclk_d_r <= sclk;
            cs_d_r   <= cs_n;
        end
    end

    // receive side: count and shift in data bits
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r   <= 5'h0;
            shift_r <= 16'h0000;
            addr_r  <= 4'h0;
        end
        else if (cs_n)
            cnt_r <= 5'h0;
        else if (fall)
        begin
            shift_r <= {shift_r[14:0], sdi};
            if (cnt_r != 5'h1f)
                cnt_r <= cnt_r + 5'h1;
            if (cnt_r == 5'(HDR_BITS - 1))
                addr_r <= {shift_r[2:0], sdi};
        end
    end

    // transmit side: read data follows the header
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            tx_r <= 11'h000;
        else if (cs_n)
            tx_r <= 11'h000;
        else if (rise)
        begin
            if (cnt_r == 5'(HDR_BITS))
                tx_r <= rd_data;
            else
                tx_r <= {tx_r[9:0], 1'b0};
        end
    end

    // a write commits when select rises after exactly one full frame
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_en   <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 11'h000;
        end
        else
        begin
            wr_en   <= ~cs_d_r ? (cs_n && cnt_r == 5'(FRAME_BITS) && !shift_r[RW_POS]) : 1'b0;
            wr_addr <= shift_r[ADDR_MSB:ADDR_LSB];
            wr_data <= shift_r[10:0];
        end
    end
endmodule
